// >>> rtl/speed_cfg_regs.sv
// Speed-loop gain, maximum speed and speed-profile duty breakpoint registers.
// Assumes an APB master on pclk; consumers read the decoded fields directly.
//
// Contract
// RL1: Bits 30-24 of the gain-limit register hold the low seven bits of the speed proportional gain code.
// RL2: The top three bits of that gain code come from bits 2-0 of the preceding closed-loop register.
// RL3: Bits 23-14 of the gain-limit register hold the ten-bit speed integral gain code, zero meaning auto.
// RL4: Bits 13-0 of the gain-limit register hold the maximum speed code, whose value over 6 is hertz.
// RL5: Bits 30-29 of the first profile register pick the profile mode and reset to zero.
// RL6: Bits 28-21 of the first profile register hold the turn-on duty point, scaled over 255.
// RL7: Bits 20-13 of the first profile register hold the turn-off duty point, scaled over 255.
// RL8: Bits 12-5 of the first profile register hold the clamp duty point, scaled over 255.
// RL9: Duty point A takes its upper five bits from first-register bits 4-0 and lower three from second 30-28.
// RL10: Duty points B, C and D sit at bits 27-20, 19-12 and 11-4 of the second profile register.
// RL11: The upper four bits of duty point E sit at bits 3-0 of the second profile register, reset zero.
// RL12: The lower four bits of duty point E sit at bits 30-27 of the third profile register.
// RL13: Bit 31 of each register is a read-write parity bit resetting to zero; the read-only status word reads zero there.
`timescale 1ns/1ps
`default_nettype none
module speed_cfg_regs (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [speed_cfg_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [speed_cfg_pkg::DATA_W-1:0]      pwdata,
    input  wire logic [3:0]                            pstrb,
    output logic      [speed_cfg_pkg::DATA_W-1:0]      prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    output logic      [speed_cfg_pkg::GAIN_W-1:0]      velocity_prop_gain,
    output logic      [speed_cfg_pkg::MANT_W-1:0]      kp_mantissa,
    output logic      [speed_cfg_pkg::EXP_W-1:0]       kp_exponent,
    output logic                                       kp_auto,
    output logic      [speed_cfg_pkg::GAIN_W-1:0]      velocity_integral_gain,
    output logic      [speed_cfg_pkg::MANT_W-1:0]      ki_mantissa,
    output logic      [speed_cfg_pkg::EXP_W-1:0]       ki_exponent,
    output logic                                       ki_auto,
    output logic      [speed_cfg_pkg::MAXS_W-1:0]      max_speed_code,
    output logic      [speed_cfg_pkg::HZ_W-1:0]        max_speed_hz,
    output speed_cfg_pkg::profile_mode_t               profile_mode,
    output logic                                       mode_speed_ref,
    output logic                                       mode_linear,
    output logic                                       mode_staircase,
    output logic                                       mode_fwd_rev,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      turn_on_duty_point,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      turn_off_duty_point,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      clamp_duty_point,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      duty_point_a,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      duty_point_b,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      duty_point_c,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      duty_point_d,
    output logic      [speed_cfg_pkg::DUTY_W-1:0]      duty_point_e,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       turn_on_pct,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       turn_off_pct,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       clamp_pct,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       duty_a_pct,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       duty_b_pct,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       duty_c_pct,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       duty_d_pct,
    output logic      [speed_cfg_pkg::PCT_W-1:0]       duty_e_pct
);
    import speed_cfg_pkg::*;

    reg_access_if ra ();

    logic [31:0] gain_upper_q;
    logic [31:0] gain_limit_q;
    logic [31:0] prof_first_q;
    logic [31:0] prof_second_q;
    logic [31:0] prof_third_q;
    logic [31:0] status_word;

    // Byte-lane merge limited to the bits a register holds
    function automatic logic [31:0] merge_write(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb,
        input logic [31:0] mask
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old_val & ~lanes) | (new_val & lanes);
    endfunction

    // Duty code to whole percent, code*100/255
    function automatic logic [PCT_W-1:0] duty_to_pct(input logic [DUTY_W-1:0] code);
        logic [15:0] prod;
        prod = 16'(code) * 16'(PCT_SCALE);
        return PCT_W'(prod / 16'(PCT_FULL));
    endfunction

    // Write strobe for one register index
    function automatic logic hit(input reg_idx_t idx);
        return ra.wr_en && (ra.index == idx);
    endfunction

    apb_reg_port u_port (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .ra      (ra)
    );

    // Upper speed proportional gain bits and parity
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_upper_q <= RST_WORD;                                // RL13
        else if (hit(IDX_GAIN_UPPER))
            gain_upper_q <= merge_write(gain_upper_q, ra.wdata, ra.wstrb, MASK_GAIN_UPPER); // RL2
    end

    // Gains and maximum speed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_limit_q <= RST_WORD;                                // RL13
        else if (hit(IDX_GAIN_LIMIT))
            gain_limit_q <= merge_write(gain_limit_q, ra.wdata, ra.wstrb, MASK_FULL); // RL1
    end

    // Mode select and first duty breakpoints
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prof_first_q <= RST_WORD;                                // RL5
        else if (hit(IDX_PROF_FIRST))
            prof_first_q <= merge_write(prof_first_q, ra.wdata, ra.wstrb, MASK_FULL); // RL6
    end

    // Second duty breakpoints
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prof_second_q <= RST_WORD;                               // RL11
        else if (hit(IDX_PROF_SECOND))
            prof_second_q <= merge_write(prof_second_q, ra.wdata, ra.wstrb, MASK_FULL); // RL10
    end

    // Low bits of breakpoint E; other fields here belong elsewhere
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prof_third_q <= RST_WORD;                                // RL13
        else if (hit(IDX_PROF_THIRD))
            prof_third_q <= merge_write(prof_third_q, ra.wdata, ra.wstrb, MASK_PROF_THIRD); // RL12
    end

    // Read-only summary of the decoded configuration
    assign status_word = {2'h0, ki_auto, kp_auto, profile_mode,
                          duty_point_e, duty_point_a, velocity_prop_gain};

    // Address map answer for the port
    always_comb
    begin
        ra.mapped   = 1'b1;
        ra.writable = 1'b1;
        ra.rdata    = RST_WORD;
        unique case (ra.index)
            IDX_GAIN_UPPER:  ra.rdata = gain_upper_q;
            IDX_GAIN_LIMIT:  ra.rdata = gain_limit_q;
            IDX_PROF_FIRST:  ra.rdata = prof_first_q;
            IDX_PROF_SECOND: ra.rdata = prof_second_q;
            IDX_PROF_THIRD:  ra.rdata = prof_third_q;
            IDX_STATUS:
            begin
                ra.rdata    = status_word;
                ra.writable = 1'b0;
            end
            default:
            begin
                ra.mapped   = 1'b0;
                ra.writable = 1'b0;
            end
        endcase
    end

    // Ten-bit gain codes, the proportional one joined across registers
    assign velocity_prop_gain = {gain_upper_q[KP_HI_LSB +: KP_HI_W],
                                 gain_limit_q[KP_LO_LSB +: KP_LO_W]};    // RL1
    assign velocity_integral_gain = gain_limit_q[KI_LSB +: GAIN_W];       // RL3
    assign max_speed_code = gain_limit_q[MAXS_LSB +: MAXS_W];             // RL4

    gain_code_split u_kp_split (
        .pclk     (pclk),
        .presetn  (presetn),
        .code     (velocity_prop_gain),
        .mantissa (kp_mantissa),
        .exponent (kp_exponent),
        .auto_sel (kp_auto)
    );

    gain_code_split u_ki_split (
        .pclk     (pclk),
        .presetn  (presetn),
        .code     (velocity_integral_gain),
        .mantissa (ki_mantissa),
        .exponent (ki_exponent),
        .auto_sel (ki_auto)
    );

    // Maximum electrical speed in hertz
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            max_speed_hz <= '0;
        else
            max_speed_hz <= HZ_W'(max_speed_code / MAXS_W'(HZ_DIV)); // RL4
    end

    // Profile mode decode
    assign profile_mode = profile_mode_t'(prof_first_q[PROF_LSB +: 2]); // RL5

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_speed_ref <= 1'b1;
            mode_linear    <= 1'b0;
            mode_staircase <= 1'b0;
            mode_fwd_rev   <= 1'b0;
        end
        else
        begin
            mode_speed_ref <= 1'b0;
            mode_linear    <= 1'b0;
            mode_staircase <= 1'b0;
            mode_fwd_rev   <= 1'b0;
            unique case (profile_mode)
                PROF_SPEED_REF: mode_speed_ref <= 1'b1;              // RL5
                PROF_LINEAR:    mode_linear    <= 1'b1;
                PROF_STAIRCASE: mode_staircase <= 1'b1;
                PROF_FWD_REV:   mode_fwd_rev   <= 1'b1;
            endcase
        end
    end

    // Duty breakpoint codes
    assign turn_on_duty_point  = prof_first_q[ON_LSB +: DUTY_W];         // RL6
    assign turn_off_duty_point = prof_first_q[OFF_LSB +: DUTY_W];        // RL7
    assign clamp_duty_point    = prof_first_q[CLAMP_LSB +: DUTY_W];      // RL8
    assign duty_point_a = {prof_first_q[A_HI_LSB +: A_HI_W],
                           prof_second_q[A_LO_LSB +: A_LO_W]};           // RL9
    assign duty_point_b = prof_second_q[B_LSB +: DUTY_W];                // RL10
    assign duty_point_c = prof_second_q[C_LSB +: DUTY_W];                // RL10
    assign duty_point_d = prof_second_q[D_LSB +: DUTY_W];                // RL10
    assign duty_point_e = {prof_second_q[E_HI_LSB +: E_PART_W],
                           prof_third_q[E_LO_LSB +: E_PART_W]};          // RL12

    // Breakpoints as whole percent of full duty
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            turn_on_pct  <= '0;
            turn_off_pct <= '0;
            clamp_pct    <= '0;
            duty_a_pct   <= '0;
            duty_b_pct   <= '0;
            duty_c_pct   <= '0;
            duty_d_pct   <= '0;
            duty_e_pct   <= '0;
        end
        else
        begin
            turn_on_pct  <= duty_to_pct(turn_on_duty_point);         // RL6
            turn_off_pct <= duty_to_pct(turn_off_duty_point);        // RL7
            clamp_pct    <= duty_to_pct(clamp_duty_point);           // RL8
            duty_a_pct   <= duty_to_pct(duty_point_a);               // RL9
            duty_b_pct   <= duty_to_pct(duty_point_b);               // RL10
            duty_c_pct   <= duty_to_pct(duty_point_c);
            duty_d_pct   <= duty_to_pct(duty_point_d);
            duty_e_pct   <= duty_to_pct(duty_point_e);               // RL12
        end
    end
endmodule // speed_cfg_regs
`default_nettype wire

// >>> pkg/speed_cfg_pkg.sv
// Constants and types for the speed-loop and speed-profile register bank.
// Assumes a 32-bit APB slave with word indices mapped to byte address index*4.
package speed_cfg_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    typedef logic [7:0] reg_idx_t;
    // Register indices; byte address is four times the index
    localparam reg_idx_t IDX_GAIN_UPPER  = 8'h8C;
    localparam reg_idx_t IDX_GAIN_LIMIT  = 8'h8E;
    localparam reg_idx_t IDX_PROF_FIRST  = 8'h94;
    localparam reg_idx_t IDX_PROF_SECOND = 8'h96;
    localparam reg_idx_t IDX_PROF_THIRD  = 8'h98;
    localparam reg_idx_t IDX_STATUS      = 8'hA0;
    // Reset value and held-bit masks
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [31:0] MASK_FULL       = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_GAIN_UPPER = 32'h8000_0007;
    localparam logic [31:0] MASK_PROF_THIRD = 32'hF800_0000;
    // Field positions
    localparam int unsigned PARITY_POS = 31;
    localparam int unsigned KP_HI_LSB  = 0;
    localparam int unsigned KP_HI_W    = 3;
    localparam int unsigned KP_LO_LSB  = 24;
    localparam int unsigned KP_LO_W    = 7;
    localparam int unsigned KI_LSB     = 14;
    localparam int unsigned GAIN_W     = 10;
    localparam int unsigned MAXS_LSB   = 0;
    localparam int unsigned MAXS_W     = 14;
    localparam int unsigned PROF_LSB   = 29;
    localparam int unsigned ON_LSB     = 21;
    localparam int unsigned OFF_LSB    = 13;
    localparam int unsigned CLAMP_LSB  = 5;
    localparam int unsigned A_HI_LSB   = 0;
    localparam int unsigned A_HI_W     = 5;
    localparam int unsigned A_LO_LSB   = 28;
    localparam int unsigned A_LO_W     = 3;
    localparam int unsigned B_LSB      = 20;
    localparam int unsigned C_LSB      = 12;
    localparam int unsigned D_LSB      = 4;
    localparam int unsigned E_HI_LSB   = 0;
    localparam int unsigned E_LO_LSB   = 27;
    localparam int unsigned E_PART_W   = 4;
    localparam int unsigned DUTY_W     = 8;
    localparam int unsigned MANT_W     = 8;
    localparam int unsigned EXP_W      = 2;
    localparam int unsigned PCT_W      = 7;
    localparam int unsigned HZ_W       = 12;
    // Scaling constants
    localparam int unsigned PCT_SCALE  = 100;
    localparam int unsigned PCT_FULL   = 255;
    localparam int unsigned HZ_DIV     = 6;
    typedef enum logic [1:0] {
        PROF_SPEED_REF,
        PROF_LINEAR,
        PROF_STAIRCASE,
        PROF_FWD_REV
    } profile_mode_t;
endpackage

// >>> pkg/reg_access_if.sv
// Carrier between the APB front end and the register bank.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic                                wr_en;
    logic                                rd_en;
    speed_cfg_pkg::reg_idx_t             index;
    logic [speed_cfg_pkg::DATA_W-1:0]    wdata;
    logic [3:0]                          wstrb;
    logic [speed_cfg_pkg::DATA_W-1:0]    rdata;
    logic                                mapped;
    logic                                writable;
    modport port (output wr_en, rd_en, index, wdata, wstrb, input rdata, mapped, writable);
    modport bank (input wr_en, rd_en, index, wdata, wstrb, output rdata, mapped, writable);
endinterface
`default_nettype wire

// >>> rtl/apb_reg_port.sv
// APB slave front end: one wait-free access phase, read data latched in setup.
// Assumes the bank answers mapped/rdata combinationally from the index.
`timescale 1ns/1ps
`default_nettype none
module apb_reg_port (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [speed_cfg_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [speed_cfg_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                         pstrb,
    output logic      [speed_cfg_pkg::DATA_W-1:0]   prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    reg_access_if.port                              ra
);
    import speed_cfg_pkg::*;
    logic aligned;
    logic bad;
    logic setup;

    // Decode word index and alignment
    assign aligned  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    assign ra.index = paddr[9:2];
    assign ra.wdata = pwdata;
    assign ra.wstrb = pstrb;
    assign setup    = psel && !penable;
    assign bad      = !aligned || !ra.mapped || (pwrite && !ra.writable);
    assign ra.rd_en = setup && !pwrite && !bad;
    assign ra.wr_en = psel && penable && pwrite && !bad;

    // Access phase always completes at once
    assign pready  = psel && penable;
    assign pslverr = psel && penable && bad;

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= RST_WORD;
        else if (setup)
            prdata <= ra.rd_en ? ra.rdata : RST_WORD;
    end
endmodule // apb_reg_port
`default_nettype wire

// >>> rtl/gain_code_split.sv
// Splits a ten-bit loop gain code into mantissa, decade exponent and auto flag.
// Assumes the code is stable configuration; outputs lag it by one clock.
`timescale 1ns/1ps
`default_nettype none
module gain_code_split (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic [speed_cfg_pkg::GAIN_W-1:0]     code,
    output logic      [speed_cfg_pkg::MANT_W-1:0]     mantissa,
    output logic      [speed_cfg_pkg::EXP_W-1:0]      exponent,
    output logic                                      auto_sel
);
    import speed_cfg_pkg::*;

    // Low byte scales, top two bits divide by a power of ten
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mantissa <= '0;
            exponent <= '0;
            auto_sel <= 1'b1;
        end
        else
        begin
            mantissa <= code[MANT_W-1:0];
            exponent <= code[GAIN_W-1:MANT_W];
            auto_sel <= (code == '0);
        end
    end
endmodule // gain_code_split
`default_nettype wire

// >>> verif/speed_cfg_regs_sva.sv
// Checker for the speed-loop and speed-profile register bank.
// Assumes it is bound to speed_cfg_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module speed_cfg_regs_sva (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [11:0]                  paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic [3:0]                   pstrb,
    input wire logic [9:0]                   velocity_prop_gain,
    input wire logic [9:0]                   velocity_integral_gain,
    input wire logic [13:0]                  max_speed_code,
    input wire logic [11:0]                  max_speed_hz,
    input wire speed_cfg_pkg::profile_mode_t profile_mode,
    input wire logic                         mode_speed_ref,
    input wire logic                         mode_linear,
    input wire logic                         mode_staircase,
    input wire logic                         mode_fwd_rev,
    input wire logic [7:0]                   turn_on_duty_point,
    input wire logic [6:0]                   turn_on_pct,
    input wire logic [7:0]                   duty_point_a,
    input wire logic [7:0]                   duty_point_e
);
    import speed_cfg_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Full-word write completing at this edge
    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a && pstrb == 4'hF;
    endsequence
    a_kp_low: assert property (s_wr(12'h238) |=> velocity_prop_gain[6:0] == $past(pwdata[30:24]))
        else $error("prop gain low bits wrong");
    a_kp_high: assert property (s_wr(12'h230) |=> velocity_prop_gain[9:7] == $past(pwdata[2:0]))
        else $error("prop gain high bits wrong");
    a_ki_field: assert property (s_wr(12'h238) |=> velocity_integral_gain == $past(pwdata[23:14]))
        else $error("integral gain wrong");
    a_max_hz: assert property (max_speed_hz == 12'($past(max_speed_code) / HZ_DIV))
        else $error("max speed hertz wrong");
    a_mode_decode: assert property ({mode_fwd_rev, mode_staircase, mode_linear, mode_speed_ref} == 4'h1 << $past(profile_mode))
        else $error("mode decode wrong");
    a_on_pct: assert property (turn_on_pct == 7'(($past(turn_on_duty_point) * 16'd100) / 16'd255))
        else $error("turn on percent wrong");
    a_duty_a: assert property (s_wr(12'h250) |=> duty_point_a[7:3] == $past(pwdata[4:0]))
        else $error("duty A upper bits wrong");
    a_duty_e: assert property (s_wr(12'h260) |=> duty_point_e[3:0] == $past(pwdata[30:27]))
        else $error("duty E lower bits wrong");
endmodule // speed_cfg_regs_sva
bind speed_cfg_regs speed_cfg_regs_sva i_speed_cfg_regs_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .velocity_prop_gain, .velocity_integral_gain, .max_speed_code, .max_speed_hz, .profile_mode,
    .mode_speed_ref, .mode_linear, .mode_staircase, .mode_fwd_rev, .turn_on_duty_point, .turn_on_pct,
    .duty_point_a, .duty_point_e);
`default_nettype wire

// >>> verif/speed_cfg_regs_tb.sv
// Self-checking bench for the speed-loop and speed-profile register bank.
// Assumes an APB slave on a 125 MHz pclk with active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module speed_cfg_regs_tb;
    import speed_cfg_pkg::*;
    logic                pclk = 1'b0;
    logic                presetn, psel, penable, pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, r;
    logic [3:0]          pstrb;
    logic                pready, pslverr, e, kp_auto, ki_auto;
    logic [9:0]          velocity_prop_gain, velocity_integral_gain;
    logic [7:0]          kp_mantissa, ki_mantissa;
    logic [1:0]          kp_exponent, ki_exponent;
    logic [13:0]         max_speed_code;
    logic [11:0]         max_speed_hz;
    profile_mode_t       profile_mode;
    wire logic [3:0]     mode_oh;
    wire logic [7:0][7:0] dp;
    wire logic [7:0][6:0] pc;
    logic [31:0]         w [5];
    logic [11:0]         ad [5] = '{12'h230, 12'h238, 12'h250, 12'h258, 12'h260};
    logic [31:0]         mk [5] = '{32'h8000_0007, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hF800_0000};
    int                  n_fail = 0, num_checks = 0;
    // Clock at 8 ns period
    always #4 pclk = ~pclk;
    speed_cfg_regs i_speed_cfg_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .velocity_prop_gain, .kp_mantissa, .kp_exponent, .kp_auto, .velocity_integral_gain,
        .ki_mantissa, .ki_exponent, .ki_auto, .max_speed_code, .max_speed_hz, .profile_mode,
        .mode_speed_ref(mode_oh[0]), .mode_linear(mode_oh[1]), .mode_staircase(mode_oh[2]),
        .mode_fwd_rev(mode_oh[3]), .turn_on_duty_point(dp[0]), .turn_off_duty_point(dp[1]),
        .clamp_duty_point(dp[2]), .duty_point_a(dp[3]), .duty_point_b(dp[4]), .duty_point_c(dp[5]),
        .duty_point_d(dp[6]), .duty_point_e(dp[7]), .turn_on_pct(pc[0]), .turn_off_pct(pc[1]), .clamp_pct(pc[2]),
        .duty_a_pct(pc[3]), .duty_b_pct(pc[4]), .duty_c_pct(pc[5]), .duty_d_pct(pc[6]), .duty_e_pct(pc[7]));
    // Compare and count
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        num_checks++;
        if (g !== x)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Duty code to whole percent
    function automatic logic [31:0] pct(logic [7:0] c);
        return (32'(c) * PCT_SCALE) / PCT_FULL;
    endfunction
    // One APB transfer, held until pready at a rising edge
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Decoded fields against the stored words
    task automatic check_fields;
        logic [7:0][7:0] x;
        logic [9:0]      kp;
        kp = {w[0][2:0], w[1][30:24]};
        x = {w[3][3:0], w[4][30:27], w[3][11:4], w[3][19:12], w[3][27:20], w[2][4:0], w[3][30:28],
             w[2][12:5], w[2][20:13], w[2][28:21]};
        chk("kp", kp, velocity_prop_gain);
        chk("kp_split", {kp == 0, kp}, {kp_auto, kp_exponent, kp_mantissa});
        chk("ki", {w[1][23:14] == 0, w[1][23:14]}, {ki_auto, ki_exponent, ki_mantissa});
        chk("max_speed", {w[1][13:0] / 6, w[1][13:0]}, {max_speed_hz, max_speed_code});
        chk("mode", {w[2][30:29], 4'h1 << w[2][30:29]}, {profile_mode, mode_oh});
        for (int j = 0; j < 8; j++)
        begin
            chk("duty", x[j], dp[j]);
            chk("pct", pct(x[j]), pc[j]);
        end
    endtask
    // Summary and verdict
    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        repeat (6000) @(posedge pclk);
        n_fail++;
        test_done();
    end
    // Main sequence
    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = '0;
        void'($urandom(10391));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk("reset_flags", 6'h07, {mode_oh, kp_auto, ki_auto});
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ad[i], 32'h0, 4'h0);
            chk("reset_word", 32'h0, r);
        end
        for (int k = 0; k < 12; k++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                w[i] = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFF_FFFF : $urandom;
                if (i == 2 && k > 1)
                    w[i][30:29] = k[1:0];
                apb(1'b1, ad[i], w[i], 4'hF);
                w[i] = w[i] & mk[i];
                chk("write_err", 1'b0, e);
            end
            repeat (2) @(posedge pclk);
            #1;
            check_fields();
            for (int i = 0; i < 5; i++)
            begin
                apb(1'b0, ad[i], 32'h0, 4'h0);
                chk("readback", w[i], r);
            end
        end
        // Refused accesses leave state alone; one-lane write
        apb(1'b1, 12'h280, 32'hFFFF_FFFF, 4'hF);
        chk("ro_err", 1'b1, e);
        apb(1'b1, 12'h252, 32'hFFFF_FFFF, 4'hF);
        chk("misalign_err", 1'b1, e);
        apb(1'b0, 12'h2F0, 32'h0, 4'h0);
        chk("unmapped_err", 1'b1, e);
        chk("unmapped_data", 32'h0, r);
        apb(1'b1, ad[3], 32'hA5A5_A5A5, 4'h2);
        apb(1'b0, ad[2], 32'h0, 4'h0);
        chk("kept", w[2], r);
        apb(1'b0, ad[3], 32'h0, 4'h0);
        chk("lane", (w[3] & 32'hFFFF_00FF) | 32'h0000_A500, r);
        apb(1'b0, 12'h280, 32'h0, 4'h0);
        chk("status", {2'h0, w[1][23:14] == 0, {w[0][2:0], w[1][30:24]} == 0, w[2][30:29], w[3][3:0], w[4][30:27],
            w[2][4:0], w[3][30:28], w[0][2:0], w[1][30:24]}, r);
        test_done();
    end
endmodule // speed_cfg_regs_tb
`default_nettype wire
